//--- tb/sfr_flash_model.sv
`timescale 1ns/1ps

module sfr_flash_model (
    // link
    input  wire       cs_n,
    input  wire       sclk,
    input  wire [3:0] io_out,
    input  wire [3:0] io_oe,
    output wire [3:0] io_in,
    // mode and monitor
    input  wire       fw,
    output reg        clash
);
    reg  [3:0]  dq;
    reg  [3:0]  doe;
    reg  [23:0] sh;
    reg  [23:0] a;
    reg  [23:0] msk;
    reg  [7:0]  op;
    reg  [7:0]  b;
    reg  [6:0]  dep;
    reg         enh;
    integer     aw, dw, dm, k;

    // released lines show the inverse of the last value, never a held copy
    assign io_in = (io_oe & io_out) | (~io_oe & ~(doe ^ dq));

    initial begin
        dq = 4'h0;
        doe = 4'h0;
        enh = 1'b0;
        clash = 1'b0;
        dep = 7'h00;
    end

    always @(io_oe or doe) if (|(io_oe & doe)) clash = 1'b1;

    task shin(input integer w, input integer n);
        integer j;
        begin
            for (j = 0; j < n; j = j + 1) begin
                @(posedge sclk);
                if (w == 1) sh = {sh[22:0], io_in[0]};
                else if (w == 2) sh = {sh[21:0], io_in[1:0]};
                else sh = {sh[19:0], io_in};
            end
        end
    endtask

    always @(negedge cs_n) begin : xfer
        op = 8'hEB;
        if (!enh) begin
            shin(fw ? 4 : 1, fw ? 2 : 8);
            op = sh[7:0];
        end
        aw = 1;
        dm = 8;
        dw = 2;
        case (op)
            8'h3B: aw = 1;
            8'hBB: begin aw = 2; dm = 4; end
            8'h6B: dw = 4;
            8'hEB: begin aw = 4; dm = 4; dw = 4; end
            8'h77: begin
                shin(fw ? 4 : 1, fw ? 2 : 8);
                dep = sh[4] ? 7'h00 : (7'h08 << sh[1:0]);
                dm = -1;
            end
            default: dm = -1;
        endcase
        if (dm >= 0) begin
            shin(aw, 24 / aw);
            a = sh;
            if (op == 8'hEB) begin
                shin(4, 2);
                enh = (sh[7:4] == ~sh[3:0]);
            end
            repeat (dm) @(posedge sclk);
            msk = (op == 8'hEB) ? {17'h0, dep} - 24'h1 : 24'hFFFFFF;
            forever begin
                b = a[7:0] ^ a[15:8] ^ 8'h3C;
                for (k = 8 - dw; k >= 0; k = k - dw) begin
                    @(negedge sclk);
                    dq = b >> k;
                    doe = (dw == 2) ? 4'h3 : 4'hF;
                end
                a = (a & ~msk) | ((a + 24'h1) & msk);
            end
        end
    end

    always @(posedge cs_n) begin
        disable xfer;
        doe = 4'h0;
    end
endmodule

//--- tb/sfr_host_sva.sv
`timescale 1ns/1ps

module sfr_host_sva #(
    parameter HALF = 4
) (
    // clock and reset
    input wire        clk,
    input wire        resetn,
    // register port
    input wire [7:0]  reg_addr,
    input wire [31:0] reg_wdata,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [31:0] reg_rdata,
    // flash pins
    input wire        cs_n,
    input wire        sclk,
    input wire [3:0]  io_in,
    input wire [3:0]  io_out,
    input wire [3:0]  io_oe
);
    reg  [7:0] hi_cnt_ff;
    wire [7:0] nxt_hi_cnt = sclk ? hi_cnt_ff + 8'h01 : 8'h00;

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hi_cnt_ff <= 8'h00;
        end else begin
            hi_cnt_ff <= nxt_hi_cnt;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_quiet;
        !sclk [*3];
    endsequence
    sequence s_first_rise;
        ##[0:3] sclk;
    endsequence

    chk_frame_start: assert property (
        $fell(cs_n) |-> s_quiet ##1 s_first_rise)
        else $error("first clock edge after select out of place");
    chk_start_drives: assert property (
        $fell(cs_n) |-> io_oe != 4'h0)
        else $error("no line driven when frame opens");
    chk_sclk_half: assert property (
        $fell(sclk) |-> {24'h0, hi_cnt_ff} == HALF)
        else $error("serial clock high phase has wrong length");
    chk_out_on_low: assert property (
        ($changed(io_out) || $changed(io_oe)) |-> !sclk)
        else $error("host lines moved while serial clock high");
    chk_oe_deselect: assert property (
        cs_n |-> io_oe == 4'h0)
        else $error("host drives lines while deselected");
    chk_cs_rise_low: assert property (
        $rose(cs_n) |-> !sclk && !$past(sclk))
        else $error("select released with serial clock high");
    chk_deselect_gap: assert property (
        $rose(cs_n) |=> cs_n [*3])
        else $error("deselect gap too short");
    chk_sclk_idle: assert property (
        cs_n |-> !sclk)
        else $error("serial clock runs while deselected");
endmodule

bind sfr_host sfr_host_sva #(.HALF(HALF)) u_sfr_host_sva (
    .clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cs_n(cs_n), .sclk(sclk), .io_in(io_in),
    .io_out(io_out), .io_oe(io_oe));

//--- tb/sfr_host_tb_top.sv
`timescale 1ns/1ps
`include "sfr_defs.vh"

module sfr_host_tb_top;
    reg         clk;
    reg         resetn;
    reg  [7:0]  reg_addr;
    reg  [31:0] reg_wdata;
    reg         reg_wr;
    reg         reg_rd;
    reg         fw;
    reg  [31:0] rv;
    reg  [31:0] seed;
    reg  [23:0] ea;
    reg  [23:0] msk;
    wire [31:0] reg_rdata;
    wire        cs_n;
    wire        sclk;
    wire [3:0]  io_in;
    wire [3:0]  io_out;
    wire [3:0]  io_oe;
    wire        clash;
    integer     miscompares, checked, i, t;

    always #50 clk = ~clk;

    sfr_host DUT (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .cs_n(cs_n), .sclk(sclk), .io_in(io_in),
        .io_out(io_out), .io_oe(io_oe));
    sfr_flash_model FLASH (.cs_n(cs_n), .sclk(sclk), .io_out(io_out),
        .io_oe(io_oe), .io_in(io_in), .fw(fw), .clash(clash));

    task check(input string nm, input [31:0] seen, input [31:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                miscompares = miscompares + 1;
                $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask

    task print_verdict;
        begin
            $display("checked %0d miscompares %0d", checked, miscompares);
            if (miscompares == 0 && checked > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask

    task wr(input [7:0] a, input [31:0] d);
        begin
            @(posedge clk);
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= 1'b1;
            @(posedge clk);
            reg_wr <= 1'b0;
        end
    endtask

    task rd(input [7:0] a, output [31:0] d);
        begin
            @(posedge clk);
            reg_addr <= a;
            reg_rd <= 1'b1;
            @(posedge clk);
            reg_rd <= 1'b0;
            @(posedge clk);
            d = reg_rdata;
        end
    endtask

    task status_bit(input integer b, input v);
        begin
            rd(`SFR_REG_STATUS, rv);
            check("status", {31'h0, rv[b]}, {31'h0, v});
        end
    endtask

    task wait_idle;
        begin
            t = 0;
            rv = 32'h1;
            while (rv[`SFR_ST_BUSY] !== 1'b0 && t < 300) begin
                rd(`SFR_REG_STATUS, rv);
                t = t + 1;
            end
            check("busy", {31'h0, rv[`SFR_ST_BUSY]}, 32'h0);
        end
    endtask

    task run_read(input [2:0] c, input kp, input [23:0] a,
                  input integer n, input integer dep, input integer stp);
        integer j;
        begin
            wr(`SFR_REG_ADDR, {8'h00, a});
            wr(`SFR_REG_LEN, n);
            wr(`SFR_REG_CTRL, {27'h0, kp, 1'b0, c});
            ea = a;
            msk = dep - 1;
            for (j = 0; j < n; j = j + 1) begin
                t = 0;
                rv = 32'h0;
                while (rv[`SFR_ST_VALID] !== 1'b1 && t < 300) begin
                    rd(`SFR_REG_STATUS, rv);
                    t = t + 1;
                end
                rd(`SFR_REG_RDATA, rv);
                check("rdata", rv, {24'h0, ea[7:0]^ea[15:8]^8'h3C});
                ea = (ea & ~msk) | ((ea + 24'h1) & msk);
                if (j == stp) begin
                    wr(`SFR_REG_CTRL, 32'h80);
                    j = n;
                end
            end
            wait_idle;
        end
    endtask

    task set_wrap(input [7:0] code);
        begin
            wr(`SFR_REG_LEN, {24'h0, code});
            wr(`SFR_REG_CTRL, {29'h0, `SFR_CMD_SET_WRAP});
            wait_idle;
        end
    endtask

    initial begin
        #3_000_000;
        miscompares = miscompares + 1;
        print_verdict;
    end

    initial begin
        clk = 1'b0;
        resetn = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        fw = 1'b0;
        miscompares = 0;
        checked = 0;
        seed = $urandom(64991);
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        rd(`SFR_REG_CFG, rv);
        check("cfg", rv, {30'h0, `SFR_CFG_RST});
        rd(`SFR_REG_LEN, rv);
        check("len", rv, {16'h0, `SFR_LEN_RST});
        rd(8'h3C, rv);
        check("unmapped", rv, 32'h0);
        for (i = 2; i < 4; i = i + 1) begin
            wr(`SFR_REG_CTRL, i);
            status_bit(`SFR_ST_ERR, 1'b1);
            wr(`SFR_REG_STATUS, 32'h8);
        end
        wr(`SFR_REG_CFG, 32'h2);
        for (i = 0; i < 4; i = i + 1) begin
            rv = $urandom;
            run_read(i[2:0], 1'b0, rv[23:0], 3, 0, 9);
        end
        run_read(`SFR_CMD_DUAL_OUT, 1'b0, 24'hFFFFFE, 3, 0, 9);
        run_read(`SFR_CMD_QUAD_IO, 1'b1, rv[23:0], 2, 0, 9);
        status_bit(`SFR_ST_ENH, 1'b1);
        wr(`SFR_REG_CTRL, {29'h0, `SFR_CMD_DUAL_IO});
        status_bit(`SFR_ST_ERR, 1'b1);
        wr(`SFR_REG_STATUS, 32'h8);
        run_read(`SFR_CMD_QUAD_IO, 1'b0, ~rv[23:0], 2, 0, 9);
        status_bit(`SFR_ST_ENH, 1'b0);
        run_read(`SFR_CMD_QUAD_IO, 1'b1, rv[31:8], 2, 0, 9);
        wr(`SFR_REG_CTRL, {29'h0, `SFR_CMD_EXIT});
        wait_idle;
        status_bit(`SFR_ST_ENH, 1'b0);
        run_read(`SFR_CMD_QUAD_IO, 1'b0, rv[27:4], 2, 0, 9);
        for (i = 0; i < 5; i = i + 1) begin
            set_wrap((i == 4) ? 8'h10 : i[7:0]);
            run_read(`SFR_CMD_QUAD_IO, 1'b0, {rv[23:6], 6'h3E}, 12,
                     (i == 4) ? 0 : (8 << i), 9);
        end
        fw <= 1'b1;
        wr(`SFR_REG_CFG, 32'h3);
        run_read(`SFR_CMD_QUAD_IO, 1'b0, rv[23:0], 3, 0, 9);
        set_wrap(8'h01);
        run_read(`SFR_CMD_QUAD_IO, 1'b0, 24'h00001D, 20, 16, 1);
        check("cs_n", {31'h0, cs_n}, 32'h1);
        check("clash", {31'h0, clash}, 32'h0);
        print_verdict;
    end
endmodule

//--- verilog/sfr_defs.vh
`ifndef SFR_DEFS_VH
`define SFR_DEFS_VH

// opcodes and indicator codes on the link
`define SFR_OP_DUAL_OUT     8'h3B
`define SFR_OP_QUAD_OUT     8'h6B
`define SFR_OP_QUAD_IO      8'hEB
`define SFR_OP_EXIT         8'hFF
`define SFR_IND_KEEP        8'hA5
`define SFR_IND_DROP        8'hFF
`define SFR_EXIT_BITS       24'hFFFFFF

// command codes written to the control register
`define SFR_CMD_DUAL_OUT    3'h0
`define SFR_CMD_DUAL_IO     3'h1
`define SFR_CMD_QUAD_OUT    3'h2
`define SFR_CMD_QUAD_IO     3'h3
`define SFR_CMD_SET_WRAP    3'h4
`define SFR_CMD_EXIT        3'h5

// register byte offsets
`define SFR_REG_CTRL        8'h00
`define SFR_REG_CFG         8'h04
`define SFR_REG_ADDR        8'h08
`define SFR_REG_LEN         8'h0C
`define SFR_REG_STATUS      8'h10
`define SFR_REG_RDATA       8'h14

// field positions
`define SFR_CTRL_KEEP       4
`define SFR_CTRL_STOP       7
`define SFR_CFG_FW          0
`define SFR_CFG_QEN         1
`define SFR_ST_BUSY         0
`define SFR_ST_VALID        1
`define SFR_ST_ENH          2
`define SFR_ST_ERR          3

// reset values
`define SFR_CFG_RST         2'h0
`define SFR_ADDR_RST        24'h000000
`define SFR_LEN_RST         16'h0001

// link clock timing
`define SFR_CLK_NS          100
`define SFR_SCLK_NS         800
`define SFR_SCLK_HALF       (`SFR_SCLK_NS / (2 * `SFR_CLK_NS))

// clocks per phase
`define SFR_OP_CLKS_1       5'd8
`define SFR_OP_CLKS_4       5'd2
`define SFR_EXIT_CLKS       5'd8
`define SFR_ADDR_BITS       5'd24
`define SFR_DUMMY_LONG      5'd8
`define SFR_DUMMY_SHORT     5'd4
`define SFR_MODE_CLKS       5'd2

`endif

//--- verilog/sfr_host.v
`timescale 1ns/1ps
`include "sfr_defs.vh"
// Functional notes
// - dual output: opcode, 3-byte address serial, 8 dummy clocks, 2-bit data
// - dual I/O: serial opcode, address and 4 dummies on two lines
// - quad_enable_bit must be set before a quad output read
// - quad output: opcode 6B, serial address, 8 dummies, 4-bit data
// - quad_enable_bit must be set before a quad I/O read (code also accepts it with only SFR_CFG_FW set)
// - quad I/O: address, 2+4 dummy cycles and data on four lines
// - host may raise chip select during data; device stops driving
// - toggling indicator nibbles keep enhance mode; next access skips opcode
// - enhance access: address, indicator, 4 dummies, data
// - exit enhance with all-ones code over 8 clocks
// - set wrap: opcode then one 8-bit wrap code under chip select

module sfr_host #(
    parameter [7:0] OP_DUAL_IO  = 8'hBB,
    parameter [7:0] OP_SET_WRAP = 8'h77,
    parameter       HALF        = `SFR_SCLK_HALF
) (
    // clock and reset
    input  wire        clk,
    input  wire        resetn,
    // register port
    input  wire [7:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output wire [31:0] reg_rdata,
    // flash pins
    output wire        cs_n,
    output wire        sclk,
    input  wire [3:0]  io_in,
    output wire [3:0]  io_out,
    output wire [3:0]  io_oe
);

    localparam [2:0] P_IDLE  = 3'h0;
    localparam [2:0] P_CMD   = 3'h1;
    localparam [2:0] P_ADDR  = 3'h2;
    localparam [2:0] P_MODE  = 3'h3;
    localparam [2:0] P_DUMMY = 3'h4;
    localparam [2:0] P_DATA  = 3'h5;
    localparam [2:0] P_WRAP  = 3'h6;
    localparam [2:0] P_DONE  = 3'h7;

    reg [2:0]  phase_ff;
    reg [2:0]  cmd_ff;
    reg        keep_ff;
    reg        stop_ff;
    reg        enh_ff;
    reg        err_ff;
    reg [1:0]  cfg_ff;
    reg [23:0] addr_ff;
    reg [15:0] len_ff;
    reg [15:0] left_ff;
    reg [23:0] sh_ff;
    reg [2:0]  wid_ff;
    reg [4:0]  cnt_ff;
    reg [7:0]  rx_ff;
    reg [3:0]  bits_ff;
    reg [7:0]  rbyte_ff;
    reg        valid_ff;
    reg        sclk_ff;
    reg        cs_n_ff;
    reg [3:0]  io_out_ff;
    reg [3:0]  io_oe_ff;
    reg [3:0]  io_s1_ff;
    reg [3:0]  io_s2_ff;
    reg [31:0] rdata_ff;

    wire tick;

    assign reg_rdata = rdata_ff;
    assign cs_n      = cs_n_ff;
    assign sclk      = sclk_ff;
    assign io_out    = io_out_ff;
    assign io_oe     = io_oe_ff;

    function [7:0] op_of;
        input [2:0] cmd;
        begin
            case (cmd)
                `SFR_CMD_DUAL_OUT: op_of = `SFR_OP_DUAL_OUT;
                `SFR_CMD_DUAL_IO:  op_of = OP_DUAL_IO;
                `SFR_CMD_QUAD_OUT: op_of = `SFR_OP_QUAD_OUT;
                `SFR_CMD_QUAD_IO:  op_of = `SFR_OP_QUAD_IO;
                `SFR_CMD_SET_WRAP: op_of = OP_SET_WRAP;
                default:           op_of = `SFR_OP_EXIT;
            endcase
        end
    endfunction

    function [2:0] first_ph;
        input [2:0] cmd;
        input       enh;
        begin
            // quad I/O opcode skipped while enhance mode holds; exit still sends its code
            if (enh && cmd == `SFR_CMD_QUAD_IO)
                first_ph = P_ADDR;
            else
                first_ph = P_CMD;
        end
    endfunction

    function [2:0] after_ph;
        input [2:0] ph;
        input [2:0] cmd;
        begin
            case (ph)
                P_CMD: begin
                    if (cmd == `SFR_CMD_EXIT)
                        after_ph = P_DONE;
                    else if (cmd == `SFR_CMD_SET_WRAP)
                        after_ph = P_WRAP;
                    else
                        after_ph = P_ADDR;
                end
                P_ADDR:  after_ph = (cmd == `SFR_CMD_QUAD_IO) ? P_MODE
                                                              : P_DUMMY;
                P_MODE:  after_ph = P_DUMMY;
                P_DUMMY: after_ph = P_DATA;
                default: after_ph = P_DONE;
            endcase
        end
    endfunction

    function [2:0] ph_lines;
        input [2:0] ph;
        input [2:0] cmd;
        input       fw;
        begin
            case (ph)
                P_CMD, P_WRAP: ph_lines = fw ? 3'd4 : 3'd1;
                P_ADDR: begin
                    if (cmd == `SFR_CMD_DUAL_IO)
                        ph_lines = 3'd2;
                    else if (cmd == `SFR_CMD_QUAD_IO)
                        ph_lines = 3'd4;
                    else
                        ph_lines = 3'd1;
                end
                P_MODE: ph_lines = 3'd4;
                default: ph_lines = (cmd == `SFR_CMD_DUAL_OUT ||
                                     cmd == `SFR_CMD_DUAL_IO) ? 3'd2 : 3'd4;
            endcase
        end
    endfunction

    function [4:0] ph_clocks;
        input [2:0] ph;
        input [2:0] cmd;
        input       fw;
        begin
            case (ph)
                P_CMD: begin
                    if (cmd == `SFR_CMD_EXIT)
                        ph_clocks = `SFR_EXIT_CLKS;
                    else
                        ph_clocks = fw ? `SFR_OP_CLKS_4 : `SFR_OP_CLKS_1;
                end
                P_WRAP: ph_clocks = fw ? `SFR_OP_CLKS_4 : `SFR_OP_CLKS_1;
                P_ADDR: begin
                    if (cmd == `SFR_CMD_DUAL_IO)
                        ph_clocks = `SFR_ADDR_BITS >> 1;
                    else if (cmd == `SFR_CMD_QUAD_IO)
                        ph_clocks = `SFR_ADDR_BITS >> 2;
                    else
                        ph_clocks = `SFR_ADDR_BITS;
                end
                P_MODE: ph_clocks = `SFR_MODE_CLKS;
                P_DUMMY: ph_clocks = (cmd == `SFR_CMD_DUAL_OUT ||
                                      cmd == `SFR_CMD_QUAD_OUT)
                                     ? `SFR_DUMMY_LONG : `SFR_DUMMY_SHORT;
                default: ph_clocks = 5'd1;
            endcase
        end
    endfunction

    function [23:0] ph_load;
        input [2:0]  ph;
        input [2:0]  cmd;
        input        keep;
        input [23:0] addr;
        input [7:0]  code;
        begin
            case (ph)
                P_CMD: begin
                    if (cmd == `SFR_CMD_EXIT)
                        ph_load = `SFR_EXIT_BITS;
                    else
                        ph_load = {op_of(cmd), 16'h0000};
                end
                P_ADDR: ph_load = addr;
                P_MODE: ph_load = keep ? {`SFR_IND_KEEP, 16'h0000}
                                       : {`SFR_IND_DROP, 16'h0000};
                P_WRAP: ph_load = {code, 16'h0000};
                default: ph_load = 24'h000000;
            endcase
        end
    endfunction

    function [23:0] shl;
        input [23:0] sh;
        input [2:0]  wid;
        begin
            case (wid)
                3'd1:    shl = {sh[22:0], 1'b0};
                3'd2:    shl = {sh[21:0], 2'b00};
                default: shl = {sh[19:0], 4'h0};
            endcase
        end
    endfunction

    function [3:0] drv_bits;
        input [23:0] sh;
        input [2:0]  wid;
        input [2:0]  cmd;
        input        fw;
        begin
            case (wid)
                3'd1:    drv_bits = {3'b000, sh[23]};
                3'd2:    drv_bits = {2'b00, sh[23:22]};
                default: drv_bits = sh[23:20];
            endcase
            // exit code is all ones; the shifter runs dry after six nibbles
            if (cmd == `SFR_CMD_EXIT)
                drv_bits = fw ? 4'hF : {3'b111, sh[23]};
        end
    endfunction

    wire       idle     = (phase_ff == P_IDLE);
    wire       wr_ctrl  = reg_wr && (reg_addr == `SFR_REG_CTRL);
    wire [2:0] w_cmd    = reg_wdata[2:0];
    wire       w_stop   = reg_wdata[`SFR_CTRL_STOP];
    wire       w_quad   = (w_cmd == `SFR_CMD_QUAD_OUT) ||
                          (w_cmd == `SFR_CMD_QUAD_IO);
    wire       w_read   = (w_cmd <= `SFR_CMD_QUAD_IO);
    wire       w_ok     = (w_cmd <= `SFR_CMD_EXIT)
                          && !(w_quad && !cfg_ff[`SFR_CFG_FW]
                               && !cfg_ff[`SFR_CFG_QEN])
                          && !(cfg_ff[`SFR_CFG_FW] && w_read
                               && w_cmd != `SFR_CMD_QUAD_IO)
                          && !(enh_ff && w_cmd != `SFR_CMD_QUAD_IO
                               && w_cmd != `SFR_CMD_EXIT)
                          && !(w_read && len_ff == 16'h0000);
    wire       start    = idle && wr_ctrl && !w_stop && w_ok;
    wire [2:0] tgt_ph   = idle ? first_ph(w_cmd, enh_ff)
                               : after_ph(phase_ff, cmd_ff);
    wire [2:0] tgt_cmd  = idle ? w_cmd : cmd_ff;
    wire       tgt_keep = idle ? reg_wdata[`SFR_CTRL_KEEP] : keep_ff;
    wire       drive    = (phase_ff == P_CMD) || (phase_ff == P_ADDR) ||
                          (phase_ff == P_MODE) || (phase_ff == P_WRAP);
    wire       in_data  = (phase_ff == P_DATA);
    wire       at_byte  = in_data && !sclk_ff && (bits_ff == 4'h0);
    wire       data_end = at_byte && (stop_ff || left_ff == 16'h0000);
    // back-pressure: no new byte is clocked until software took the last
    wire       stall    = at_byte && valid_ff;
    wire       run      = !idle && !stall && !data_end;
    wire [7:0] rx_new   = (wid_ff == 3'd1) ? {rx_ff[6:0], io_s2_ff[1]} :
                          (wid_ff == 3'd2) ? {rx_ff[5:0], io_s2_ff[1:0]} :
                                             {rx_ff[3:0], io_s2_ff};
    wire [3:0] bits_new = bits_ff + {1'b0, wid_ff};
    wire       byte_in  = in_data && tick && !sclk_ff
                          && (bits_new == 4'h8);
    wire       rd_pop   = reg_rd && (reg_addr == `SFR_REG_RDATA);

    sfr_tick_gen #(
        .HALF   (HALF)
    ) u_tick (
        .clk    (clk),
        .resetn (resetn),
        .run    (run),
        .tick   (tick)
    );

    // pins are asynchronous to clk
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            io_s1_ff <= 4'h0;
            io_s2_ff <= 4'h0;
        end else begin
            io_s1_ff <= io_in;
            io_s2_ff <= io_s1_ff;
        end
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            phase_ff <= P_IDLE;
            cmd_ff   <= `SFR_CMD_DUAL_OUT;
            keep_ff  <= 1'b0;
            stop_ff  <= 1'b0;
            enh_ff   <= 1'b0;
            err_ff   <= 1'b0;
            cfg_ff   <= `SFR_CFG_RST;
            addr_ff  <= `SFR_ADDR_RST;
            len_ff   <= `SFR_LEN_RST;
            left_ff  <= 16'h0000;
            sh_ff    <= 24'h000000;
            wid_ff   <= 3'd1;
            cnt_ff   <= 5'd0;
            rx_ff    <= 8'h00;
            bits_ff  <= 4'h0;
            rbyte_ff <= 8'h00;
            valid_ff <= 1'b0;
            sclk_ff  <= 1'b0;
        end else begin
            if (idle && reg_wr && reg_addr == `SFR_REG_CFG)
                cfg_ff <= reg_wdata[1:0];
            if (idle && reg_wr && reg_addr == `SFR_REG_ADDR)
                addr_ff <= reg_wdata[23:0];
            if (idle && reg_wr && reg_addr == `SFR_REG_LEN)
                len_ff <= reg_wdata[15:0];
            if (reg_wr && reg_addr == `SFR_REG_STATUS
                && reg_wdata[`SFR_ST_ERR])
                err_ff <= 1'b0;
            if (wr_ctrl && w_stop && !idle)
                stop_ff <= 1'b1;
            if (idle && wr_ctrl && !w_stop && !w_ok)
                err_ff <= 1'b1;
            // a byte landing with the pop keeps valid set
            if (rd_pop)
                valid_ff <= 1'b0;
            if (start) begin
                phase_ff <= tgt_ph;
                cmd_ff   <= w_cmd;
                keep_ff  <= tgt_keep;
                stop_ff  <= 1'b0;
                left_ff  <= len_ff;
                wid_ff   <= ph_lines(tgt_ph, tgt_cmd, cfg_ff[`SFR_CFG_FW]);
                cnt_ff   <= ph_clocks(tgt_ph, tgt_cmd, cfg_ff[`SFR_CFG_FW]);
                sh_ff    <= ph_load(tgt_ph, tgt_cmd, tgt_keep, addr_ff,
                                    len_ff[7:0]);
            end else if (data_end) begin
                phase_ff <= P_DONE;
            end else if (tick && phase_ff == P_DONE) begin
                phase_ff <= P_IDLE;
            end else if (tick && !sclk_ff) begin
                sclk_ff <= 1'b1;
                if (in_data) begin
                    rx_ff <= rx_new;
                    if (byte_in) begin
                        bits_ff  <= 4'h0;
                        rbyte_ff <= rx_new;
                        valid_ff <= 1'b1;
                        left_ff  <= left_ff - 16'h0001;
                    end else begin
                        bits_ff <= bits_new;
                    end
                end
            end else if (tick) begin
                sclk_ff <= 1'b0;
                if (!in_data && cnt_ff == 5'd1) begin
                    if (phase_ff == P_MODE)
                        enh_ff <= keep_ff;
                    if (cmd_ff == `SFR_CMD_EXIT)
                        enh_ff <= 1'b0;
                    phase_ff <= tgt_ph;
                    wid_ff   <= ph_lines(tgt_ph, cmd_ff,
                                         cfg_ff[`SFR_CFG_FW]);
                    cnt_ff   <= ph_clocks(tgt_ph, cmd_ff,
                                          cfg_ff[`SFR_CFG_FW]);
                    sh_ff    <= ph_load(tgt_ph, cmd_ff, keep_ff, addr_ff,
                                        len_ff[7:0]);
                    bits_ff  <= 4'h0;
                end else if (!in_data) begin
                    cnt_ff <= cnt_ff - 5'd1;
                    sh_ff  <= shl(sh_ff, wid_ff);
                end
            end
        end
    end

    // pin drive lags the phase by one clk, well inside a half period
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cs_n_ff   <= 1'b1;
            io_out_ff <= 4'h0;
            io_oe_ff  <= 4'h0;
        end else begin
            cs_n_ff <= idle || (phase_ff == P_DONE);
            if (drive) begin
                io_out_ff <= drv_bits(sh_ff, wid_ff, cmd_ff,
                                      cfg_ff[`SFR_CFG_FW]);
                io_oe_ff  <= (cmd_ff == `SFR_CMD_EXIT) ? 4'hF :
                             (wid_ff == 3'd1) ? 4'h1 :
                             (wid_ff == 3'd2) ? 4'h3 : 4'hF;
            end else begin
                io_out_ff <= 4'h0;
                io_oe_ff  <= 4'h0;
            end
        end
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_ff <= 32'h00000000;
        end else if (reg_rd) begin
            case (reg_addr)
                `SFR_REG_CTRL:   rdata_ff <= {27'h0, keep_ff, 1'b0, cmd_ff};
                `SFR_REG_CFG:    rdata_ff <= {30'h0, cfg_ff};
                `SFR_REG_ADDR:   rdata_ff <= {8'h00, addr_ff};
                `SFR_REG_LEN:    rdata_ff <= {16'h0000, len_ff};
                `SFR_REG_STATUS: rdata_ff <= {28'h0, err_ff, enh_ff,
                                              valid_ff, !idle};
                `SFR_REG_RDATA:  rdata_ff <= {24'h000000, rbyte_ff};
                default:         rdata_ff <= 32'h00000000;
            endcase
        end else begin
            rdata_ff <= 32'h00000000;
        end
    end

endmodule

//--- verilog/sfr_tick_gen.v
`timescale 1ns/1ps

module sfr_tick_gen #(
    parameter HALF = 4
) (
    // clock and reset
    input  wire clk,
    input  wire resetn,
    // control
    input  wire run,
    output wire tick
);

    reg [7:0] cnt_ff;
    reg       tick_ff;

    assign tick = tick_ff;

    // counter restarts whenever run drops, so a stall keeps a full half period
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_ff  <= 8'h00;
            tick_ff <= 1'b0;
        end else if (!run) begin
            cnt_ff  <= 8'h00;
            tick_ff <= 1'b0;
        end else if (cnt_ff == HALF[7:0] - 8'h01) begin
            cnt_ff  <= 8'h00;
            tick_ff <= 1'b1;
        end else begin
            cnt_ff  <= cnt_ff + 8'h01;
            tick_ff <= 1'b0;
        end
    end

endmodule
